//--- verilog/cbw_pkg.sv
/*
 * cbw_pkg: shared constants, types and helpers for the cell balance
 * watchdog and emergency discharge block.
 * assumes: one 25 MHz pclk, APB register access, twelve balancing cells.
 */
package cbw_pkg;
	// clock and tick timing
	localparam int unsigned CLK_HZ          = 25_000_000;        // pclk rate
	localparam int unsigned TICK_US         = 62_500;            // base tick, 62.5 ms
	localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
	localparam int unsigned TICKS_PER_HALF  = 8;                 // 0.5 s in base ticks
	localparam int unsigned TICKS_PER_SEC   = 16;                // 1 s in base ticks
	// discharge cycle shape in base ticks, timeout step in minutes
	localparam logic [9:0]  CYCLE_LAST      = 10'h3BF;           // 960 ticks = 1 minute
	localparam logic [9:0]  DUTY_STEP_TICKS = 10'h078;           // 7.5 s per duty code
	localparam logic [9:0]  MAX_ON_TICKS    = 10'h3BF;           // 59.9375 s, leaves 62.5 ms
	localparam logic [2:0]  DUTY_MAX_CODE   = 3'h7;
	localparam logic [15:0] MIN_PER_STEP    = 16'h0078;          // 2 hours per timeout step
	// cell parity masks, bit 0 is cell one
	localparam logic [11:0] ODD_CELLS       = 12'h555;
	localparam logic [11:0] EVEN_CELLS      = 12'hAAA;
	// register byte offsets
	localparam logic [7:0]  OFS_BAL_EN      = 8'h00;
	localparam logic [7:0]  OFS_WATCHDOG    = 8'h04;
	localparam logic [7:0]  OFS_DCHG_PAT    = 8'h08;
	localparam logic [7:0]  OFS_DEV_CFG1    = 8'h0C;
	localparam logic [7:0]  OFS_PIN_CFG     = 8'h10;
	localparam logic [7:0]  OFS_STATUS      = 8'h14;
	localparam logic [7:0]  OFS_DRIVE       = 8'h18;
	// field positions
	localparam int unsigned WD_COUNT_LSB    = 0;                 // countdown [3:0]
	localparam int unsigned WD_PRESC_LSB    = 8;                 // prescale [10:8]
	localparam int unsigned CFG_TIME_LSB    = 0;                 // timeout [7:0]
	localparam int unsigned CFG_DUTY_LSB    = 8;                 // duty [10:8]
	localparam int unsigned CFG_EMG_BIT     = 12;                // emergency enable
	localparam int unsigned PIN_TMR_BIT     = 0;                 // timer output select
	localparam int unsigned PIN_VAL_BIT     = 1;                 // normal pin level
	localparam int unsigned ST_ALIVE_LSB    = 0;                 // alive counter [3:0]
	localparam int unsigned ST_ACTIVE_BIT   = 4;
	localparam int unsigned ST_EXPIRED_BIT  = 5;
	localparam int unsigned ST_RUNNING_BIT  = 6;
	localparam int unsigned ST_ALERT_BIT    = 15;                // reset alert flag
	// values after reset
	localparam logic        RST_ALERT       = 1'b1;              // power-on is recorded
	localparam logic [11:0] RST_SWITCHES    = 12'h000;
	localparam logic [3:0]  RST_COUNT       = 4'h0;
	localparam logic [2:0]  RST_PRESC       = 3'h0;
	localparam logic [7:0]  RST_TIMEOUT     = 8'h00;

	// discharge mode states
	typedef enum logic [1:0] {CBW_IDLE, CBW_ACTIVE, CBW_DONE} cbw_state_t;

	// apb request from master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cbw_apb_req_t;

	// apb answer to master
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cbw_apb_rsp_t;

	// seconds per countdown step, zero when the timer is off
	function automatic logic [8:0] cbw_step_secs(input logic [2:0] sel);
		case (sel)
			3'h1:    cbw_step_secs = 9'h001;
			3'h2:    cbw_step_secs = 9'h004;
			3'h3:    cbw_step_secs = 9'h010;
			3'h4:    cbw_step_secs = 9'h040;
			3'h5:    cbw_step_secs = 9'h080;
			3'h6:    cbw_step_secs = 9'h100;
			default: cbw_step_secs = 9'h000;
		endcase
	endfunction : cbw_step_secs

	// switch on-time in base ticks for a duty code
	function automatic logic [9:0] cbw_on_ticks(input logic [2:0] code);
		logic [9:0] steps;
		steps = {7'h00, code} + 10'h001;
		if (code == DUTY_MAX_CODE) begin
			cbw_on_ticks = MAX_ON_TICKS;
		end else begin
			cbw_on_ticks = 10'(steps * DUTY_STEP_TICKS);
		end
	endfunction : cbw_on_ticks
endpackage : cbw_pkg

//--- verilog/cbw_sync.sv
/*
 * cbw_sync: three flop synchroniser for a level from outside pclk.
 * assumes: the level is slow against pclk; a change counts once the
 * second and third flops agree.
 */
module cbw_sync (
	input  wire logic pclk,     // block clock
	input  wire logic presetn,  // async reset, active low
	input  wire logic ce,       // clock enable
	input  wire logic async_in, // raw pin level
	output logic      level_q,  // filtered level
	output logic      rise_q    // one cycle on a filtered rise
);
	logic s1_q;                 // first stage, only read by s2
	logic s2_q;                 // second stage
	logic s3_q;                 // third stage
	wire  agree = (s2_q == s3_q);

	// shift chain and filtered level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
			rise_q  <= 1'b0;
		end else if (ce) begin
			s1_q    <= async_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= agree ? s3_q : level_q;
			rise_q  <= agree && s3_q && !level_q;
		end
	end
endmodule : cbw_sync

//--- verilog/cbw_tick_gen.sv
/*
 * cbw_tick_gen: free running divider giving base, half second and
 * second ticks for both timers.
 * assumes: TICK_CYCLES pclk cycles per 62.5 ms base tick.
 */
module cbw_tick_gen #(
	parameter int unsigned TICK_CYCLES = cbw_pkg::TICK_CYCLES // cycles per base tick
) (
	input  wire logic pclk,    // block clock
	input  wire logic presetn, // async reset, active low
	input  wire logic ce,      // clock enable
	output logic      tick_q,  // one cycle per 62.5 ms
	output logic      half_q,  // one cycle per 0.5 s
	output logic      sec_q    // one cycle per 1 s
);
	import cbw_pkg::*;
	localparam logic [31:0] DIV_LAST = 32'(TICK_CYCLES - 1);
	logic [31:0] div_q;        // cycle divider
	logic [3:0]  sub_q;        // base ticks within a second
	wire         wrap = (div_q == DIV_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q  <= 32'h0000_0000;
			sub_q  <= 4'h0;
			tick_q <= 1'b0;
			half_q <= 1'b0;
			sec_q  <= 1'b0;
		end else if (ce) begin
			div_q  <= wrap ? 32'h0000_0000 : div_q + 32'h0000_0001;
			sub_q  <= wrap ? sub_q + 4'h1 : sub_q;
			tick_q <= wrap;
			half_q <= wrap && (sub_q[2:0] == 3'(TICKS_PER_HALF - 1));
			sec_q  <= wrap && (sub_q == 4'(TICKS_PER_SEC - 1));
		end
	end
endmodule : cbw_tick_gen

//--- verilog/cbw_top.sv
/*
 * cbw_top: balancing watchdog, emergency discharge sequencer, pin three
 * control and reset alert flag, behind an APB register slave.
 * assumes: APB master per the usual two phase protocol; the undervoltage
 * detector level arrives asynchronously; switch outputs drive the cells.
 */
// The APB register port and the placing of the registers were left to the implementer.
// Notes on behaviour
// - expiry forces every switch off outside discharge mode
// - expiry leaves switch-enable register untouched
// - prescale selector picks step period
// - countdown decrements once per step period
// - expired stays off until disable or reload
// - pin three high while countdown runs
// - discharge starts on enable with nonzero timeout
// - discharge entry clears the countdown
// - discharge drives switches from pattern register
// - alive counter counts at 2 Hz
// - pin three high during discharge
// - alternate odd then even one-minute cycles
// - each cycle ends with 62.5 ms off
// - duty code sets on-time in 7.5 s
// - timeout is two hours per step
// - clearing enable ends mode, restores control
// - zero timeout or elapsed limit ends mode
// - undervoltage reset sets alert flag bit 15
module cbw_top #(
	parameter int unsigned TICK_CYCLES = cbw_pkg::TICK_CYCLES // shorten for simulation
) (
	input  wire logic                 pclk,           // block clock, 25 MHz
	input  wire logic                 presetn,        // async reset, active low
	input  wire logic                 ce,             // clock enable, freezes state
	input  wire cbw_pkg::cbw_apb_req_t apb_req,       // apb request
	output cbw_pkg::cbw_apb_rsp_t     apb_rsp,        // apb answer
	input  wire logic                 supply_uv_in,   // regulator undervoltage level
	output logic [11:0]               switch_drive_q, // balancing switch drive
	output logic                      general_pin_three // pin three level
);
	import cbw_pkg::*;

	// register state
	logic [11:0] balance_switch_enable_reg_q;   // normal switch request
	logic [11:0] discharge_switch_pattern_q;    // discharge switch request
	logic [3:0]  balance_countdown_q;           // watchdog countdown
	logic [2:0]  balance_prescale_sel_q;        // step period select
	logic [8:0]  presc_secs_q;                  // seconds into current step
	logic [7:0]  discharge_timeout_q;           // mode duration field
	logic [2:0]  discharge_duty_sel_q;          // on-time field
	logic        emergency_discharge_en_q;      // mode enable
	logic        pin_three_timer_output_sel_q;  // pin three follows timer
	logic        pin_three_value_q;             // pin three normal level
	logic        reset_alert_flag_q;            // sticky reset alert
	logic [3:0]  discharge_alive_counter_q;     // 2 Hz alive count
	// sequencer state
	cbw_state_t  state_q;                       // discharge mode state
	cbw_state_t  state_d;
	logic [9:0]  cyc_q;                         // base ticks within cycle
	logic        even_phase_q;                  // low: odd cells, high: even
	logic [15:0] elapsed_min_q;                 // minutes in the mode
	logic [31:0] prdata_q;                      // read data register
	logic        pslverr_q;                     // error register
	logic        pin_q;                         // pin three register
	logic [11:0] switch_drive_d;
	logic        pin_d;

	// ticks and synchronised alert input
	logic tick_w;                               // 62.5 ms tick
	logic half_w;                               // 0.5 s tick
	logic sec_w;                                // 1 s tick
	logic uv_rise_w;                            // undervoltage event

	cbw_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_ticks (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.tick_q  (tick_w),
		.half_q  (half_w),
		.sec_q   (sec_w)
	);

	cbw_sync u_uv_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.async_in (supply_uv_in),
		.level_q  (),
		.rise_q   (uv_rise_w)
	);

	// apb decode
	wire        setup_w   = apb_req.psel && !apb_req.penable;
	wire        access_w  = apb_req.psel && apb_req.penable;
	wire        wr_w      = access_w && apb_req.pwrite && ce;
	wire [7:0]  addr_w    = apb_req.paddr;
	wire [31:0] wdata_w   = apb_req.pwdata;
	wire        hit_w     = (addr_w <= OFS_DRIVE) && (addr_w[1:0] == 2'h0); // aligned word map
	wire        wr_bal_w  = wr_w && (addr_w == OFS_BAL_EN);
	wire        wr_wd_w   = wr_w && (addr_w == OFS_WATCHDOG);
	wire        wr_pat_w  = wr_w && (addr_w == OFS_DCHG_PAT);
	wire        wr_cfg_w  = wr_w && (addr_w == OFS_DEV_CFG1);
	wire        wr_pin_w  = wr_w && (addr_w == OFS_PIN_CFG);
	wire        wr_st_w   = wr_w && (addr_w == OFS_STATUS);

	// watchdog decode
	wire [8:0]  step_w     = cbw_step_secs(balance_prescale_sel_q);
	wire        wd_on_w    = (step_w != 9'h000);
	wire        wd_run_w   = wd_on_w && (balance_countdown_q != 4'h0);
	wire        wd_exp_w   = wd_on_w && (balance_countdown_q == 4'h0);
	wire        step_end_w = sec_w && wd_run_w && (presc_secs_q == step_w - 9'h001);

	// discharge decode
	wire        active_w   = (state_q == CBW_ACTIVE);
	wire        start_w    = emergency_discharge_en_q && (discharge_timeout_q != 8'h00);
	wire [15:0] limit_w    = 16'(({8'h00, discharge_timeout_q} + 16'h0001) * MIN_PER_STEP);
	wire        cyc_end_w  = tick_w && (cyc_q == CYCLE_LAST);
	wire [9:0]  on_w       = cbw_on_ticks(discharge_duty_sel_q);
	wire        on_win_w   = (cyc_q < on_w);
	wire [11:0] parity_w   = even_phase_q ? EVEN_CELLS : ODD_CELLS;

	// read mux
	wire [31:0] status_w   = (32'(reset_alert_flag_q) << ST_ALERT_BIT) |
	                         (32'(wd_run_w) << ST_RUNNING_BIT) |
	                         (32'(wd_exp_w) << ST_EXPIRED_BIT) |
	                         (32'(active_w) << ST_ACTIVE_BIT) |
	                         (32'(discharge_alive_counter_q) << ST_ALIVE_LSB);
	wire [31:0] rd_w       = (addr_w == OFS_BAL_EN)   ? {20'h00000, balance_switch_enable_reg_q} :
	                         (addr_w == OFS_WATCHDOG) ?
	                           ((32'(balance_prescale_sel_q) << WD_PRESC_LSB) |
	                            (32'(balance_countdown_q) << WD_COUNT_LSB)) :
	                         (addr_w == OFS_DCHG_PAT) ? {20'h00000, discharge_switch_pattern_q} :
	                         (addr_w == OFS_DEV_CFG1) ?
	                           ((32'(emergency_discharge_en_q) << CFG_EMG_BIT) |
	                            (32'(discharge_duty_sel_q) << CFG_DUTY_LSB) |
	                            (32'(discharge_timeout_q) << CFG_TIME_LSB)) :
	                         (addr_w == OFS_PIN_CFG)  ?
	                           ((32'(pin_three_value_q) << PIN_VAL_BIT) |
	                            (32'(pin_three_timer_output_sel_q) << PIN_TMR_BIT)) :
	                         (addr_w == OFS_STATUS)   ? status_w :
	                         (addr_w == OFS_DRIVE)    ? {20'h00000, switch_drive_q} :
	                         32'h0000_0000;

	// zero wait state answer
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.prdata  = prdata_q;
	assign apb_rsp.pslverr = pslverr_q;

	// read data and error caught in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (ce && setup_w) begin
			prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : rd_w;
			pslverr_q <= !hit_w;
		end
	end

	// enable register only changes by writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			balance_switch_enable_reg_q  <= RST_SWITCHES;
			discharge_switch_pattern_q   <= RST_SWITCHES;
			balance_prescale_sel_q       <= RST_PRESC;
			discharge_timeout_q          <= RST_TIMEOUT;
			discharge_duty_sel_q         <= 3'h0;
			emergency_discharge_en_q     <= 1'b0;
			pin_three_timer_output_sel_q <= 1'b0;
			pin_three_value_q            <= 1'b0;
		end else begin
			if (wr_bal_w) begin
				balance_switch_enable_reg_q <= wdata_w[11:0];
			end
			if (wr_pat_w) begin
				discharge_switch_pattern_q <= wdata_w[11:0];
			end
			if (wr_wd_w) begin
				balance_prescale_sel_q <= wdata_w[WD_PRESC_LSB +: 3];
			end
			if (wr_cfg_w) begin
				discharge_timeout_q      <= wdata_w[CFG_TIME_LSB +: 8];
				discharge_duty_sel_q     <= wdata_w[CFG_DUTY_LSB +: 3];
				emergency_discharge_en_q <= wdata_w[CFG_EMG_BIT];
			end
			if (wr_pin_w) begin
				pin_three_timer_output_sel_q <= wdata_w[PIN_TMR_BIT];
				pin_three_value_q            <= wdata_w[PIN_VAL_BIT];
			end
		end
	end

	// sticky alert, set wins over write one to clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_alert_flag_q <= RST_ALERT;
		end else if (ce) begin
			if (uv_rise_w) begin
				reset_alert_flag_q <= 1'b1;
			end else if (wr_st_w && wdata_w[ST_ALERT_BIT]) begin
				reset_alert_flag_q <= 1'b0;
			end
		end
	end

	// countdown steps once per selected period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			balance_countdown_q <= RST_COUNT;
			presc_secs_q        <= 9'h000;
		end else if (ce) begin
			if (state_q == CBW_IDLE && start_w) begin
				balance_countdown_q <= 4'h0;
				presc_secs_q        <= 9'h000;
			end else if (wr_wd_w) begin
				// reload restarts the step
				balance_countdown_q <= wdata_w[WD_COUNT_LSB +: 4];
				presc_secs_q        <= 9'h000;
			end else if (!wd_run_w) begin
				presc_secs_q <= 9'h000;
			end else if (step_end_w) begin
				balance_countdown_q <= balance_countdown_q - 4'h1;
				presc_secs_q        <= 9'h000;
			end else if (sec_w) begin
				presc_secs_q <= presc_secs_q + 9'h001;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			CBW_IDLE: begin
				if (start_w) begin
					state_d = CBW_ACTIVE;
				end
			end
			CBW_ACTIVE: begin
				if (!emergency_discharge_en_q) begin
					state_d = CBW_IDLE;
				end else if (discharge_timeout_q == 8'h00 || elapsed_min_q >= limit_w) begin
					state_d = CBW_DONE;
				end
			end
			CBW_DONE: begin
				// waits for the enable to drop
				if (!emergency_discharge_en_q) begin
					state_d = CBW_IDLE;
				end
			end
			default: state_d = CBW_IDLE;
		endcase
	end

	// cycle position, phase and elapsed time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q       <= CBW_IDLE;
			cyc_q         <= 10'h000;
			even_phase_q  <= 1'b0;
			elapsed_min_q <= 16'h0000;
		end else if (ce) begin
			state_q <= state_d;
			if (!active_w) begin
				// timer reset outside the mode
				cyc_q         <= 10'h000;
				even_phase_q  <= 1'b0;
				elapsed_min_q <= 16'h0000;
			end else if (cyc_end_w) begin
				cyc_q         <= 10'h000;
				even_phase_q  <= !even_phase_q;
				elapsed_min_q <= elapsed_min_q + 16'h0001;
			end else if (tick_w) begin
				cyc_q <= cyc_q + 10'h001;
			end
		end
	end

	// alive counter wraps after its top value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			discharge_alive_counter_q <= 4'h0;
		end else if (ce && active_w && half_w) begin
			discharge_alive_counter_q <= discharge_alive_counter_q + 4'h1;
		end
	end

	wire [11:0] dchg_drive_w = on_win_w ? (discharge_switch_pattern_q & parity_w) : 12'h000; // mode
	wire [11:0] norm_drive_w = wd_exp_w ? 12'h000 : balance_switch_enable_reg_q;            // normal
	assign switch_drive_d = active_w ? dchg_drive_w : norm_drive_w;

	wire        pin_norm_w   = pin_three_timer_output_sel_q ? wd_run_w : pin_three_value_q; // normal
	assign pin_d = active_w || pin_norm_w;

	// output registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_drive_q <= RST_SWITCHES;
			pin_q          <= 1'b0;
		end else if (ce) begin
			switch_drive_q <= switch_drive_d;
			pin_q          <= pin_d;
		end
	end
	assign general_pin_three = pin_q;

	// checks on the control paths
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_expiry_forces_off: assert property (
		ce && wd_exp_w && !active_w |=> switch_drive_q == 12'h000)
		else $error("switches not off after watchdog expiry");
	chk_enable_reg_kept: assert property (
		ce && wd_exp_w |=> $stable(balance_switch_enable_reg_q) || $past(wr_bal_w))
		else $error("enable register changed without a write");
	chk_step_period: assert property (
		ce && step_end_w && !wr_wd_w && !(state_q == CBW_IDLE && start_w)
		|=> balance_countdown_q == $past(balance_countdown_q) - 4'h1)
		else $error("countdown did not step at period end");
	chk_entry_clears: assert property (
		ce && state_q == CBW_IDLE && start_w |=> balance_countdown_q == 4'h0 && active_w)
		else $error("discharge entry did not clear countdown");
	chk_pattern_source: assert property (
		ce && active_w |=> (switch_drive_q & ~$past(discharge_switch_pattern_q)) == 12'h000)
		else $error("switch outside discharge pattern");
	chk_alive_rate: assert property (
		ce && active_w && half_w |=> discharge_alive_counter_q == $past(discharge_alive_counter_q) + 4'h1)
		else $error("alive counter missed a half second");
	chk_pin_active: assert property (
		ce && active_w |=> general_pin_three)
		else $error("pin three low during discharge");
	chk_off_gap: assert property (
		ce && active_w && cyc_q == CYCLE_LAST |=> switch_drive_q == 12'h000)
		else $error("no off time at cycle end");
	chk_parity_phase: assert property (
		ce && active_w && !even_phase_q |=> (switch_drive_q & EVEN_CELLS) == 12'h000)
		else $error("even cell on during odd cycle");
	chk_exit_on_clear: assert property (
		ce && state_q != CBW_IDLE && !emergency_discharge_en_q |=> state_q == CBW_IDLE)
		else $error("mode did not end on enable clear");
	chk_timeout_end: assert property (
		ce && active_w && emergency_discharge_en_q && elapsed_min_q >= limit_w
		|=> state_q == CBW_DONE)
		else $error("mode did not end at timeout");
	chk_zero_timeout_end: assert property (
		ce && active_w && emergency_discharge_en_q && discharge_timeout_q == 8'h00
		|=> state_q == CBW_DONE)
		else $error("mode did not end on zero timeout");
	chk_alert_sets: assert property (
		ce && uv_rise_w |=> reset_alert_flag_q)
		else $error("undervoltage event lost");

	cov_enter_mode:   cover property (state_q == CBW_IDLE ##1 state_q == CBW_ACTIVE);
	cov_wd_expiry:    cover property (wd_run_w ##1 wd_exp_w);
	cov_phase_toggle: cover property (active_w && cyc_end_w && !even_phase_q);
	cov_timeout_done: cover property (active_w ##1 state_q == CBW_DONE);
endmodule : cbw_top

//--- test/cbw_cell_model.sv
/* cbw_cell_model: far-side bank of balancing switches and resistors.
   assumes: drive bit 0 is cell one, one bit per conducting switch. */
module cbw_cell_model (
	input  wire logic        pclk,  // block clock
	input  wire logic [11:0] drive, // switch drive
	output logic [3:0]       n_on   // switches conducting
);
	timeunit 1ns;
	timeprecision 1ns;
	// count the resistors carrying current
	always_ff @(posedge pclk) begin
		n_on <= 4'($countones(drive));
	end
endmodule : cbw_cell_model

//--- test/cbw_top_tb_top.sv
/* cbw_top_tb_top: apb-driven checks of watchdog, discharge and alert.
   assumes: zero-wait apb slave, base tick shortened to 4 cycles. */
module cbw_top_tb_top;
	import cbw_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic         pclk;        // block clock
	logic         presetn;     // reset, active low
	logic         uv;          // undervoltage level
	logic         ce;          // clock enable
	cbw_apb_req_t req;         // apb request
	cbw_apb_rsp_t rsp;         // apb answer
	logic [11:0]  drv;         // switch drive
	logic         pin3;        // pin three
	logic [3:0]   n_on;        // switches conducting
	logic [31:0]  rd;          // read data
	logic         er;          // read error
	logic [3:0]   alive;       // first alive sample
	int           secs[6] = '{1, 4, 16, 64, 128, 256}; // seconds per step
	int           n_mismatch;  // mismatches
	int           checks_done; // comparisons
	// 1 s = 64 cycles, 1 min = 3840 cycles
	cbw_top #(.TICK_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce),
		.apb_req(req), .apb_rsp(rsp), .supply_uv_in(uv), .switch_drive_q(drv),
		.general_pin_three(pin3));
	cbw_cell_model u_cells (.pclk(pclk), .drive(drv), .n_on(n_on));
	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// verdict and end of run
	task automatic end_sim();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	// one comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one apb transfer, held until pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask : xfer
	// masked register read and compare
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask : rchk
	// let edges pass, end settled
	task automatic wcyc(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask : wcyc
	// hang guard
	initial begin
		repeat (60000) @(posedge pclk);
		n_mismatch++;
		end_sim();
	end
	// main sequence
	initial begin
		req = '0;
		uv = 1'b0;
		ce = 1'b1;
		presetn = 1'b0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rchk("alert", OFS_STATUS, 32'h8000, 32'h8000);
		xfer(1'b1, OFS_STATUS, 32'h8000);
		rchk("alert clear", OFS_STATUS, 32'h8000, 32'h0);
		uv <= 1'b1;
		wcyc(8);
		rchk("alert uv", OFS_STATUS, 32'h8000, 32'h8000);
		xfer(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		xfer(1'b1, OFS_BAL_EN, 32'hFFF);
		xfer(1'b1, OFS_PIN_CFG, 32'h1);
		// prescale codes 1 to 6, each with a count of one
		for (int i = 0; i < 6; i++) begin
			xfer(1'b1, OFS_WATCHDOG, 32'h1 | ((i + 1) << 8));
			wcyc((secs[i] - 1) * 60 + 2);
			chk("drive running", 32'hFFF, drv);
			chk("pin running", 32'h1, pin3);
			wcyc(secs[i] * 4 + 70);
			chk("drive expired", 32'h0, drv);
			chk("pin expired", 32'h0, pin3);
		end
		rchk("enable kept", OFS_BAL_EN, 32'hFFF, 32'hFFF);
		wcyc(100);
		chk("drive held off", 32'h0, drv);
		xfer(1'b1, OFS_WATCHDOG, 32'h00F);
		wcyc(2);
		chk("timer off", 32'hFFF, drv);
		xfer(1'b1, OFS_DCHG_PAT, 32'hFFF);
		xfer(1'b1, OFS_DEV_CFG1, 32'h1000);
		wcyc(4);
		chk("no start", 32'hFFF, drv);
		xfer(1'b1, OFS_DEV_CFG1, 32'h0);
		xfer(1'b1, OFS_DEV_CFG1, 32'h1001);
		rchk("count cleared", OFS_WATCHDOG, 32'hF, 32'h0);
		wcyc(10);
		chk("odd cells", 32'h555, drv);
		chk("cells on", 32'h6, n_on);
		chk("pin discharge", 32'h1, pin3);
		xfer(1'b0, OFS_STATUS, 32'h0);
		alive = rd[3:0];
		wcyc(317);
		rchk("alive", OFS_STATUS, 32'hF, {28'h0, 4'(alive + 4'hA)});
		wcyc(160);
		chk("duty off", 32'h0, drv);
		wcyc(3350);
		chk("even cells", 32'hAAA, drv);
		xfer(1'b1, OFS_DEV_CFG1, 32'h0);
		wcyc(2);
		chk("drive restored", 32'hFFF, drv);
		chk("pin restored", 32'h0, pin3);
		xfer(1'b1, OFS_DEV_CFG1, 32'h1701);
		wcyc(3400);
		chk("long duty", 32'h555, drv);
		xfer(1'b1, OFS_DEV_CFG1, 32'h1700);
		wcyc(2);
		chk("zero timeout", 32'hFFF, drv);
		xfer(1'b1, OFS_DEV_CFG1, 32'h1701);
		rchk("done held", OFS_STATUS, 32'h10, 32'h0);
		ce <= 1'b0;
		xfer(1'b1, OFS_BAL_EN, 32'h0);
		ce <= 1'b1;
		rchk("ce frozen", OFS_BAL_EN, 32'hFFF, 32'hFFF);
		end_sim();
	end
endmodule : cbw_top_tb_top
